// file: bench/compare_array_pwm_properties.sv
// port checks for the compare array pwm block
`timescale 1ns/100ps
module compare_array_pwm_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic channel_a_pin,
	input wire logic channel_b_pin,
	input wire logic channel_c_pin,
	input wire logic channel_d_pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ----
	// pins and bus handshakes
	// ----
	chk_pins_reset:
		assert property ($rose(reset_n) |-> {channel_a_pin, channel_b_pin, channel_c_pin, channel_d_pin} == 4'hf)
		else $error("pins not high after reset");
	chk_write_answer:
		assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
	chk_read_answer:
		assert property (arvalid && arready |=> rvalid) else $error("read answer late");
	chk_b_hold:
		assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
	chk_r_hold:
		assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)) else $error("read data dropped");
	chk_ar_block:
		assert property (rvalid |-> !arready) else $error("read accepted while answering");
	chk_aw_block:
		assert property (bvalid |-> !awready && !wready) else $error("write accepted while answering");
	chk_b_release:
		assert property (bvalid && bready |=> !bvalid && awready && wready) else $error("write channel not released");
	chk_r_release:
		assert property (rvalid && rready |=> !rvalid && arready) else $error("read channel not released");
endmodule
bind compare_array_pwm compare_array_pwm_checker compare_array_pwm_checker_inst (
	.clk, .reset_n, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
	.rdata, .rresp, .rvalid, .rready, .channel_a_pin, .channel_b_pin, .channel_c_pin, .channel_d_pin
);

// file: bench/compare_array_pwm_test.sv
// self-checking bench for the compare array pwm block
`timescale 1ns/100ps
module compare_array_pwm_test;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic channel_a_pin, channel_b_pin, channel_c_pin, channel_d_pin;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd_data;
	int n_fail = 0;
	int samples_checked = 0;

	always #50 clk = ~clk;

	compare_array_pwm compare_array_pwm_inst (.clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .channel_a_pin, .channel_b_pin, .channel_c_pin, .channel_d_pin);
	pin_load pin_load_inst (.clk, .pins({channel_d_pin, channel_c_pin, channel_b_pin, channel_a_pin}));

	// ----
	// bus and report tasks
	// ----
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic lost(input string nm);
		n_fail++;
		$display("FAIL %s expected handshake seen timeout", nm);
		results();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ad;
		logic dd;
		@(posedge clk);
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 40 && !(ad && dd); n++) begin
			@(posedge clk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!dd && wready === 1'b1) begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		if (!(ad && dd)) lost("write accept");
		for (n = 0; n < 40 && bvalid !== 1'b1; n++) @(posedge clk);
		if (bvalid !== 1'b1) lost("write answer");
		bready <= 1'b1;
		@(posedge clk);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (arready !== 1'b1 && n < 40);
		if (arready !== 1'b1) lost("read accept");
		arvalid <= 1'b0;
		for (n = 0; n < 40 && rvalid !== 1'b1; n++) @(posedge clk);
		if (rvalid !== 1'b1) lost("read answer");
		rready <= 1'b1;
		@(posedge clk);
		rd_data = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic chan(input int c, input logic [3:0] f, input logic [15:0] v);
		wr(8'(8'h10 + 4 * c), {28'h0, f});
		wr(8'(8'h20 + 4 * c), {16'h0, v});
	endtask

	// settle long enough for one full period and a buffer load before counting
	task automatic meas(input int cyc, input int e [4]);
		int s [4];
		int i;
		repeat (300) @(posedge clk);
		s = pin_load_inst.hi;
		repeat (cyc) @(posedge clk);
		for (i = 0; i < 4; i++) check($sformatf("high cycles ch%0d", i), e[i], pin_load_inst.hi[i] - s[i]);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset();
		rd(8'h04);
		check("top reset", 32'h0000ffff, rd_data);
		wr(8'h08, 32'h00001234);
		check("count write resp", 32'h0, resp);
		rd(8'h08);
		check("count stopped", 32'h0, rd_data);
		rd(8'h40);
		check("unmapped read resp", 32'h2, resp);
		wr(8'h44, 32'h1);
		check("unmapped write resp", 32'h2, resp);
	endtask

	// period of 266 cycles: an 8-bit truncation of top or compare would be seen
	task automatic t_edge();
		wr(8'h04, 32'h00000109);
		chan(0, 4'h8, 16'h0103);
		chan(1, 4'hb, 16'h0103);
		chan(2, 4'h9, 16'h0000);
		chan(3, 4'h9, 16'h0200);
		wr(8'h00, 32'h3);
		meas(532, '{532, 518, 532, 0});
		chan(0, 4'h9, 16'h0103);
		chan(2, 4'hb, 16'h0000);
		chan(3, 4'hb, 16'h0109);
		meas(532, '{14, 518, 0, 532});
		rd(8'h0c);
		check("pin levels c and d", 32'h2, {30'h0, rd_data[4:3]});
		rd(8'h08);
		check("count range", 32'h1, {31'h0, rd_data[15:0] <= 16'h0109});
	endtask

	task automatic t_centre();
		int m;
		int e [4];
		for (m = 0; m < 2; m++) begin
			wr(8'h00, 32'h0);
			wr(8'h04, 32'h8);
			chan(0, 4'h9, 16'h0002);
			chan(1, 4'hb, 16'h0002);
			chan(2, {2'h2, m[0], 1'h1}, 16'h0000);
			chan(3, {2'h2, m[0], 1'h1}, 16'h0009);
			wr(8'h00, {28'h0, 2'h1, m[0], 1'h1});
			e = '{40, 120, 0, 160};
			if (m == 1) e = '{40, 120, 160, 0};
			meas(160, e);
			wr(8'h0c, 32'h1);
			repeat (20) @(posedge clk);
			rd(8'h0c);
			check("overflow flag", 32'h1, {31'h0, rd_data[0]});
			rd(8'h08);
			check("centre count range", 32'h1, {31'h0, rd_data[15:0] <= 16'h0008});
		end
	endtask

	task automatic t_phase();
		int k;
		int i;
		int e [4];
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h9);
		for (k = 0; k < 4; k++) chan(k, 4'h9, 16'h0005);
		for (k = 1; k < 5; k++) begin
			wr(8'h00, 32'h0);
			wr(8'h00, {23'h0, k > 2, 3'(k), 5'h0});
			wr(8'h00, {23'h0, k > 2, 3'(k), 5'h3});
			e = '{600, 600, 600, 600};
			for (i = 0; i < 4; i++) begin
				if (k == 4) e[i] = 300;
				else if (i <= k) e[i] = 600 / (k + 1);
			end
			meas(1200, e);
		end
	endtask

	initial begin
		repeat (5) @(posedge clk);
		check("pins in reset", 32'hf, {28'h0, channel_d_pin, channel_c_pin, channel_b_pin, channel_a_pin});
		reset_n <= 1'b1;
		t_reset();
		t_edge();
		t_centre();
		t_phase();
		results();
	end
endmodule

// file: bench/pin_load.sv
// load model on the four pwm pins that counts cycles spent high
`timescale 1ns/100ps
module pin_load (
	input wire logic clk,
	input wire logic [3:0] pins
);
	int hi [4] = '{0, 0, 0, 0};
	// non-blocking so a reader at the same edge always sees the count before it
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (pins[i] === 1'b1) begin
				hi[i] <= hi[i] + 1;
			end
		end
	end
endmodule

// file: hw/compare_array_pwm.sv
// four-channel compare array pwm with axi4-lite registers
// Function
// RULE1 - channel is pwm when compare select is 1 and action field is 10x
// RULE2 - compare value is double-buffered, writes apply at the update point
// RULE3 - polarity selectable, inverting swaps set and clear actions
// RULE4 - resolution follows top, full 16-bit count and compare
// RULE5 - edge-aligned mode 01 counts zero to top then restarts at zero
// RULE6 - edge non-inverting: set on match, cleared at zero
// RULE7 - edge inverting: cleared on match, set at zero
// RULE8 - edge mode loads top and compare buffers only at top-to-zero overflow
// RULE9 - edge compare at or above top: low non-inverting, high inverting
// RULE10 - edge compare zero: high non-inverting, low inverting
// RULE11 - centre mode 1x counts up to top, one clock at top, then down
// RULE12 - centre non-inverting: low on up match, high on down match
// RULE13 - centre inverting: high on up match, low on down match
// RULE14 - centre mode loads top at underflow; compare update point set by variant
// RULE15 - centre compare at/above top: high non-inv; zero: low non-inv; inverted otherwise
// RULE16 - mode 10: compare load and overflow flag only at underflow
// RULE17 - mode 11: compare load and overflow flag at underflow and at top
// RULE18 - phase field selects normal, 1:2, 1:3, 1:4 or 2:4 alternation
// RULE19 - phase gating by one-hot shift; blocked channels act as compare equals top
// RULE20 - direction bit steps a-b-c-d or reversed, may change any time
// RULE21 - software changes phase field only while stopped, gated channels are pwm
// RULE22 - non-pwm channels ignore gating but keep slots; unused slots run normal
// RULE23 - all channel pins are 1 after reset
// RULE24 - phase shift advances at the start of every pwm period
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pwm_array_defines.svh"
module compare_array_pwm (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic channel_a_pin,
	output logic channel_b_pin,
	output logic channel_c_pin,
	output logic channel_d_pin
);
	pwm_array_pkg::main_state_t s_r;
	pwm_array_pkg::main_state_t s_nxt;

	logic timer_go;
	logic [15:0] count;
	logic down;
	logic [15:0] top_active;
	logic wrap_evt;
	logic top_evt;
	logic bottom_evt;
	logic period_start;
	logic [3:0] enable_mask;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_pwm(input logic [3:0] cfg);
		is_pwm = cfg[`CFG_SEL] && (cfg[`CFG_ACT] == `ACT_PWM); // RULE1
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = val[b*8 +: 8];
			end
		end
		merge = res;
	endfunction

	// a byte address inside a word is refused, so software never lands on a neighbour
	function automatic logic is_cfg(input logic [7:0] addr);
		is_cfg = (addr[`ADDR_LSB] == `WORD_ALIGN) && (addr[`ADDR_PAGE] == `CFG_PAGE);
	endfunction

	function automatic logic is_val(input logic [7:0] addr);
		is_val = (addr[`ADDR_LSB] == `WORD_ALIGN) && (addr[`ADDR_PAGE] == `VAL_PAGE);
	endfunction

	// word index inside a page picks the channel
	function automatic logic [1:0] chan_idx(input logic [7:0] addr);
		chan_idx = addr[`ADDR_IDX];
	endfunction

	// both dual-slope variants share the output rules, only the load points and the overflow flag points differ
	function automatic logic is_centre(input logic [1:0] mode);
		is_centre = (mode == `CM_PFC) || (mode == `CM_PC);
	endfunction

	function automatic logic reg_hit(input logic [7:0] addr);
		reg_hit = (addr == `OFS_CTRL) || (addr == `OFS_TOP) || (addr == `OFS_COUNT) ||
			(addr == `OFS_STATUS) || is_cfg(addr) || is_val(addr);
	endfunction

	// ----------------------------------------------------------------
	// timer and phase shift
	// ----------------------------------------------------------------
	// auto-reload with up/down disabled is the only timer setup that counts
	// count mode 00 leaves the timer frozen and the pins untouched
	assign timer_go = s_r.ctrl[`CTRL_RUN] && !s_r.ctrl[`CTRL_CRS] && !s_r.ctrl[`CTRL_UDEN];
	assign period_start = wrap_evt || bottom_evt; // RULE24

	pwm_timer u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.run(timer_go),
		.count_mode(s_r.ctrl[`CTRL_MODE]),
		.top_buf(s_r.top_buf),
		.count(count),
		.down(down),
		.top_active(top_active),
		.wrap_evt(wrap_evt),
		.top_evt(top_evt),
		.bottom_evt(bottom_evt)
	);

	phase_gate u_phase (
		.clk(clk),
		.reset_n(reset_n),
		.run(timer_go),
		.phase_mode(s_r.ctrl[`CTRL_PHS]),
		.direction(s_r.ctrl[`CTRL_PHASE_DIRECTION_BIT]),
		.advance(period_start),
		.enable_mask(enable_mask)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] wv;
		logic [1:0] widx;
		logic [1:0] ridx;
		logic load;
		logic inv;
		logic ceil;
		logic match;
		logic [15:0] cmp;
		wv = 32'h0000_0000;
		widx = chan_idx(s_r.aw_addr);
		ridx = chan_idx(araddr);
		load = 1'b0;
		inv = 1'b0;
		ceil = 1'b0;
		match = 1'b0;
		cmp = `ZERO16;
		s_nxt = s_r;

		// ----------------------------------------------------------------
		// write channel
		// ----------------------------------------------------------------
		// address and data are taken in either order
		if (awvalid && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.w_data = wdata;
			s_nxt.w_strb = wstrb;
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = reg_hit(s_r.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
			// the count is read-only: a write to it answers okay and changes nothing
			if (s_r.aw_addr == `OFS_CTRL) begin
				wv = merge({23'h000000, s_r.ctrl}, s_r.w_data, s_r.w_strb);
				s_nxt.ctrl = wv[8:0];
			end else if (s_r.aw_addr == `OFS_TOP) begin
				wv = merge({16'h0000, s_r.top_buf}, s_r.w_data, s_r.w_strb);
				s_nxt.top_buf = wv[15:0];
			end else if (s_r.aw_addr == `OFS_STATUS) begin
				if (s_r.w_strb[0] && s_r.w_data[`ST_TF]) begin
					s_nxt.tf = 1'b0;
				end
			end else if (is_cfg(s_r.aw_addr)) begin
				wv = merge({28'h0000000, s_r.cfg[widx]}, s_r.w_data, s_r.w_strb);
				s_nxt.cfg[widx] = wv[3:0];
			end else if (is_val(s_r.aw_addr)) begin
				// software only reaches the buffer copy
				wv = merge({16'h0000, s_r.cmp_buf[widx]}, s_r.w_data, s_r.w_strb);
				s_nxt.cmp_buf[widx] = wv[15:0]; // RULE2
			end
		end
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

		// ----------------------------------------------------------------
		// read channel
		// ----------------------------------------------------------------
		// one read in flight, data from a register
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = reg_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			s_nxt.rdata = 32'h0000_0000;
			if (araddr == `OFS_CTRL) begin
				s_nxt.rdata = {23'h000000, s_r.ctrl};
			end else if (araddr == `OFS_TOP) begin
				s_nxt.rdata = {16'h0000, s_r.top_buf};
			end else if (araddr == `OFS_COUNT) begin
				s_nxt.rdata = {15'h0000, down, count};
			end else if (araddr == `OFS_STATUS) begin
				s_nxt.rdata = {27'h0000000, s_r.pins, s_r.tf};
			end else if (is_cfg(araddr)) begin
				s_nxt.rdata = {28'h0000000, s_r.cfg[ridx]};
			end else if (is_val(araddr)) begin
				s_nxt.rdata = {16'h0000, s_r.cmp_buf[ridx]};
			end
		end
		s_nxt.arready = !s_nxt.rvalid;

		// ----------------------------------------------------------------
		// overflow flag
		// ----------------------------------------------------------------
		// a new event wins over a clear in the same cycle
		if (wrap_evt || bottom_evt) begin
			s_nxt.tf = 1'b1; // RULE16
		end
		if (top_evt && s_r.ctrl[`CTRL_MODE] == `CM_PC) begin
			s_nxt.tf = 1'b1; // RULE17
		end

		// ----------------------------------------------------------------
		// buffer transfer
		// ----------------------------------------------------------------
		// compare buffer transfer point depends on the counting variant
		if (!timer_go) begin
			// stopped: buffers pass through so a restart begins with fresh values
			load = 1'b1;
		end else if (s_r.ctrl[`CTRL_MODE] == `CM_EDGE) begin
			load = wrap_evt; // RULE8
		end else if (s_r.ctrl[`CTRL_MODE] == `CM_PFC) begin
			load = bottom_evt; // RULE14 RULE16
		end else if (s_r.ctrl[`CTRL_MODE] == `CM_PC) begin
			load = bottom_evt || top_evt; // RULE17
		end

		// ----------------------------------------------------------------
		// channel output stage
		// ----------------------------------------------------------------
		for (int i = 0; i < 4; i++) begin
			if (load) begin
				s_nxt.cmp_act[i] = s_r.cmp_buf[i]; // RULE2
			end
			cmp = s_r.cmp_act[i];
			inv = s_r.cfg[i][`CFG_POL]; // RULE3
			// a channel masked out by the phase shift behaves as if compare were top
			ceil = !enable_mask[i] || (cmp >= top_active); // RULE19 RULE4
			match = (count == cmp); // RULE4
			// non-pwm channels are untouched and keep their last level
			if (is_pwm(s_r.cfg[i]) && s_r.ctrl[`CTRL_MODE] == `CM_EDGE) begin // RULE22
				if (ceil) begin
					s_nxt.pins[i] = inv; // RULE9
				end else if (cmp == `ZERO16) begin
					s_nxt.pins[i] = !inv; // RULE10
				end else if (match) begin
					s_nxt.pins[i] = !inv; // RULE6 RULE7
				end else if (count == `ZERO16) begin
					s_nxt.pins[i] = inv; // RULE6 RULE7
				end
			end else if (is_pwm(s_r.cfg[i]) && is_centre(s_r.ctrl[`CTRL_MODE])) begin
				if (ceil) begin
					s_nxt.pins[i] = !inv; // RULE15
				end else if (cmp == `ZERO16) begin
					s_nxt.pins[i] = inv; // RULE15
				end else if (match && !down) begin
					s_nxt.pins[i] = inv; // RULE12 RULE13
				end else if (match && down) begin
					s_nxt.pins[i] = !inv; // RULE12 RULE13
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{
				awready: 1'b1,
				wready: 1'b1,
				aw_held: 1'b0,
				w_held: 1'b0,
				aw_addr: 8'h00,
				w_data: 32'h0000_0000,
				w_strb: 4'h0,
				bvalid: 1'b0,
				bresp: `RESP_OKAY,
				arready: 1'b1,
				rvalid: 1'b0,
				rdata: 32'h0000_0000,
				rresp: `RESP_OKAY,
				ctrl: 9'h000,
				top_buf: `TOP_RESET,
				cfg: '0,
				cmp_buf: '0,
				cmp_act: '0,
				pins: `PIN_RESET, // RULE23
				tf: 1'b0
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bresp = s_r.bresp;
	assign bvalid = s_r.bvalid;
	assign arready = s_r.arready;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;
	assign rvalid = s_r.rvalid;
	assign channel_a_pin = s_r.pins[0];
	assign channel_b_pin = s_r.pins[1];
	assign channel_c_pin = s_r.pins[2];
	assign channel_d_pin = s_r.pins[3];
endmodule

// file: hw/phase_gate.sv
// rotating channel enable for multi-phasic pwm
`timescale 1ns/100ps
`include "pwm_array_defines.svh"
module phase_gate (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [2:0] phase_mode,
	input wire logic direction,
	input wire logic advance,
	output logic [3:0] enable_mask
);
	pwm_array_pkg::phase_state_t s_r;
	pwm_array_pkg::phase_state_t s_nxt;
	pwm_array_pkg::slot_t last;

	always_comb begin
		last = (phase_mode == `PHS_1OF3) ? pwm_array_pkg::SLOT2 :
			(phase_mode == `PHS_1OF4) ? pwm_array_pkg::SLOT3 : pwm_array_pkg::SLOT1;
		s_nxt = s_r;
		if (!run) begin
			s_nxt.slot = direction ? last : pwm_array_pkg::SLOT0;
		end else if (advance) begin
			// direction is read live, so it may change at any time
			unique case (s_r.slot)
				pwm_array_pkg::SLOT0: s_nxt.slot = direction ? last : pwm_array_pkg::SLOT1; // RULE20 RULE24
				pwm_array_pkg::SLOT1: s_nxt.slot = direction ? pwm_array_pkg::SLOT0 :
					((last == pwm_array_pkg::SLOT1) ? pwm_array_pkg::SLOT0 : pwm_array_pkg::SLOT2);
				pwm_array_pkg::SLOT2: s_nxt.slot = direction ? pwm_array_pkg::SLOT1 :
					((last == pwm_array_pkg::SLOT2) ? pwm_array_pkg::SLOT0 : pwm_array_pkg::SLOT3);
				pwm_array_pkg::SLOT3: s_nxt.slot = direction ? pwm_array_pkg::SLOT2 : pwm_array_pkg::SLOT0;
			endcase
		end
		// the mode is assumed stable while the timer runs
		case (phase_mode) // RULE18 RULE21
			`PHS_1OF2: enable_mask = {2'b11, s_r.slot == pwm_array_pkg::SLOT1, s_r.slot == pwm_array_pkg::SLOT0};
			`PHS_1OF3: enable_mask = {1'b1, s_r.slot == pwm_array_pkg::SLOT2, s_r.slot == pwm_array_pkg::SLOT1,
				s_r.slot == pwm_array_pkg::SLOT0}; // RULE22
			`PHS_1OF4: enable_mask = {s_r.slot == pwm_array_pkg::SLOT3, s_r.slot == pwm_array_pkg::SLOT2,
				s_r.slot == pwm_array_pkg::SLOT1, s_r.slot == pwm_array_pkg::SLOT0};
			`PHS_2OF4: enable_mask = {s_r.slot == pwm_array_pkg::SLOT1, s_r.slot == pwm_array_pkg::SLOT0,
				s_r.slot == pwm_array_pkg::SLOT1, s_r.slot == pwm_array_pkg::SLOT0};
			default: enable_mask = `MASK_ALL;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{slot: pwm_array_pkg::SLOT0};
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// file: hw/pwm_timer.sv
// shared 16-bit timer with single-slope and dual-slope counting
`timescale 1ns/100ps
`include "pwm_array_defines.svh"
module pwm_timer (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [1:0] count_mode,
	input wire logic [15:0] top_buf,
	output logic [15:0] count,
	output logic down,
	output logic [15:0] top_active,
	output logic wrap_evt,
	output logic top_evt,
	output logic bottom_evt
);
	pwm_array_pkg::timer_state_t s_r;
	pwm_array_pkg::timer_state_t s_nxt;

	always_comb begin
		wrap_evt = run && (count_mode == `CM_EDGE) && (s_r.count >= s_r.top_act);
		top_evt = run && count_mode[1] && !s_r.down && (s_r.count >= s_r.top_act);
		bottom_evt = run && count_mode[1] && s_r.down && (s_r.count == `ZERO16);
		s_nxt = s_r;
		if (!run) begin
			// stopped: top passes straight through so the first period uses it
			s_nxt.top_act = top_buf;
		end else if (count_mode == `CM_EDGE) begin
			if (wrap_evt) begin
				s_nxt.count = `ZERO16; // RULE5
				s_nxt.top_act = top_buf; // RULE8
			end else begin
				s_nxt.count = 16'(s_r.count + `ONE16); // RULE5
			end
		end else if (count_mode[1]) begin
			if (bottom_evt) begin
				s_nxt.down = 1'b0;
				s_nxt.count = 16'(s_r.count + `ONE16); // RULE11
				s_nxt.top_act = top_buf; // RULE14
			end else if (top_evt || s_r.down) begin
				// top is seen for one clock only, then the count turns down
				s_nxt.down = 1'b1; // RULE11
				s_nxt.count = 16'(s_r.count - `ONE16);
			end else begin
				s_nxt.count = 16'(s_r.count + `ONE16);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{count: `ZERO16, down: 1'b0, top_act: `TOP_RESET};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.count;
	assign down = s_r.down;
	assign top_active = s_r.top_act;
endmodule

// file: pkg/pwm_array_defines.svh
// named offsets, field positions, codes and reset values of the compare array pwm block
`ifndef PWM_ARRAY_DEFINES_SVH
`define PWM_ARRAY_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_TOP 8'h04
`define OFS_COUNT 8'h08
`define OFS_STATUS 8'h0c
`define CFG_PAGE 4'h1
`define VAL_PAGE 4'h2
`define WORD_ALIGN 2'b00
`define ADDR_LSB 1:0
`define ADDR_IDX 3:2
`define ADDR_PAGE 7:4
`define CTRL_RUN 0
`define CTRL_MODE 2:1
`define CTRL_CRS 3
`define CTRL_UDEN 4
`define CTRL_PHS 7:5
`define CTRL_PHASE_DIRECTION_BIT 8
`define CFG_SEL 0
`define CFG_ACT 3:2
`define CFG_POL 1
`define ST_TF 0
`define CM_EDGE 2'b01
`define CM_PFC 2'b10
`define CM_PC 2'b11
`define ACT_PWM 2'b10
`define PHS_OFF 3'h0
`define PHS_1OF2 3'h1
`define PHS_1OF3 3'h2
`define PHS_1OF4 3'h3
`define PHS_2OF4 3'h4
`define MASK_ALL 4'hf
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define PIN_RESET 4'hf
`define TOP_RESET 16'hffff
`define ZERO16 16'h0000
`define ONE16 16'h0001
`endif

// file: pkg/pwm_array_pkg.sv
// types of the compare array pwm block
package pwm_array_pkg;
	typedef enum logic [1:0] {
		SLOT0 = 2'b00,
		SLOT1 = 2'b01,
		SLOT2 = 2'b11,
		SLOT3 = 2'b10
	} slot_t;
	typedef struct packed {
		logic [15:0] count;
		logic down;
		logic [15:0] top_act;
	} timer_state_t;
	typedef struct packed {
		slot_t slot;
	} phase_state_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [8:0] ctrl;
		logic [15:0] top_buf;
		logic [3:0][3:0] cfg;
		logic [3:0][15:0] cmp_buf;
		logic [3:0][15:0] cmp_act;
		logic [3:0] pins;
		logic tf;
	} main_state_t;
endpackage
